// file: lmf_params.svh
`ifndef LMF_PARAMS_SVH
`define LMF_PARAMS_SVH
// System clock period
`define LMF_CLK_PERIOD_NS 20
// Insert pulse train timing
`define LMF_INS_PERIOD_NS 16000
`define LMF_INS_HIGH_NS 2000
`define LMF_INS_PERIOD_CYC \
  ((`LMF_INS_PERIOD_NS + `LMF_CLK_PERIOD_NS - 1) / `LMF_CLK_PERIOD_NS)
`define LMF_INS_HIGH_CYC \
  ((`LMF_INS_HIGH_NS + `LMF_CLK_PERIOD_NS - 1) / `LMF_CLK_PERIOD_NS)
// Collision must stand this many transmit clock edges
`define LMF_ETH_COLLISION_IN_MIN_EDGES 2
// Register offsets
`define LMF_ADDR_CTRL 8'h00
`define LMF_ADDR_STATUS 8'h04
`define LMF_ADDR_TXDATA 8'h08
`define LMF_ADDR_RXDATA 8'h0c
`define LMF_ADDR_IRQ_STAT 8'h10
`define LMF_ADDR_IRQ_CLR 8'h14
`define LMF_ADDR_IRQ_EN 8'h18
// Control fields
`define LMF_CTRL_WIDE 0
`define LMF_CTRL_INSERT 1
`define LMF_CTRL_LOOP 2
`define LMF_CTRL_W 3
`define LMF_CTRL_RESET 3'h0
// Event bits
`define LMF_EV_RX 0
`define LMF_EV_TX 1
`define LMF_EV_FAULT 2
`define LMF_EV_ETH_COLLISION_IN 3
`define LMF_EV_W 4
// Status fields
`define LMF_ST_MODE_LSB 0
`define LMF_ST_VALID 2
`define LMF_ST_FAULT 3
`define LMF_ST_ETH_COLLISION_IN 4
`define LMF_ST_BUSY 5
`endif

// file: lmf_pkg.sv
package lmf_pkg;
  // Function of the shared media pins
  typedef enum logic [1:0] {LMF_RING, LMF_ETH, LMF_RSVD} lmf_mode_type;

  // Decode the two network select levels
  function automatic lmf_mode_type lmf_mode_of(input logic b1,
                                               input logic b2);
    lmf_mode_type m;
    m = LMF_RSVD;
    if (b2 && b1) begin
      m = LMF_RING;
    end else if (b2) begin
      m = LMF_ETH;
    end
    return m;
  endfunction : lmf_mode_of
endpackage : lmf_pkg

// file: lmf_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a group of unrelated levels
module lmf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("lmf_sync needs WIDTH of at least one");
    end
  endgenerate

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : lmf_sync

// file: lmf_edge.sv
`timescale 1ns/1ps
// Rise and fall pulses of already synchronised levels
module lmf_edge #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Level in, one-cycle pulses out
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] prev_reg;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("lmf_edge needs WIDTH of at least one");
    end
  endgenerate

  // Previous sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;
endmodule : lmf_edge

// file: lmf_port.sv
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "lmf_params.svh"
module lmf_port #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Network select straps
  input  wire logic        net_select_b1,
  input  wire logic        net_select_b2,
  // Shared media inputs
  input  wire logic        media_ref_txc,
  input  wire logic        media_rclk_rxc,
  input  wire logic        media_rx_bit,
  input  wire logic        media_ready_crs,
  input  wire logic        media_fault_eth_collision_in,
  // Media outputs
  output logic             ring_tx_diff_out_p,
  output logic             ring_tx_diff_out_n,
  output logic             media_acq_txd,
  output logic             media_insert_loop,
  output logic             media_wrap_eth_tx_active,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Interrupt
  output logic             irq
);
  import lmf_pkg::*;

  localparam int CW = $clog2(DATA_W + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DATA_W);
  localparam int INS_P = `LMF_INS_PERIOD_CYC;
  localparam int INS_CW = $clog2(INS_P);
  localparam logic [INS_CW-1:0] INS_LAST = INS_CW'(INS_P - 1);
  localparam logic [INS_CW-1:0] INS_HIGH = INS_CW'(`LMF_INS_HIGH_CYC);
  localparam logic [1:0] ETH_COLLISION_IN_MIN = 2'(`LMF_ETH_COLLISION_IN_MIN_EDGES);

  generate
    if (DATA_W < 1 || DATA_W > 32) begin : g_chk
      $error("lmf_port DATA_W must be 1 to 32");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input sampling
  logic                rst_meta_reg;
  logic                rst_n;
  logic [6:0]          sync_w;
  logic [2:0]          rise_w;
  logic [2:0]          fall_w;
  logic                sel_b1;
  logic                sel_b2;
  logic                rx_bit;
  logic                ready_crs;
  logic                fault_eth_collision_in;
  logic                txc_rise;
  logic                rxc_rise;
  logic                fault_fall;

  // Reset asserts at once and leaves on the clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  lmf_sync #(.WIDTH(7)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  ({net_select_b1, net_select_b2, media_ref_txc, media_rclk_rxc,
             media_rx_bit, media_ready_crs, media_fault_eth_collision_in}),
    .q_out (sync_w)
  );

  assign sel_b1     = sync_w[6];
  assign sel_b2     = sync_w[5];
  assign rx_bit     = sync_w[2];
  assign ready_crs  = sync_w[1];
  assign fault_eth_collision_in = sync_w[0];

  // Link clocks are slow against clk, so edges are found by sampling
  lmf_edge #(.WIDTH(3)) u_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .level ({sync_w[4], sync_w[3], sync_w[0]}),
    .rise  (rise_w),
    .fall  (fall_w)
  );

  assign txc_rise   = rise_w[2];
  assign rxc_rise   = rise_w[1];
  assign fault_fall = fall_w[0];

  ////////////////////////////////////////////////////////////////////////////
  // Mode
  lmf_mode_type mode_reg;
  logic         is_ring;
  logic         is_eth;
  logic         rx_valid;

  // Selects are meant to change only in reset; tracked anyway
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= LMF_RSVD;
    end else begin
      mode_reg <= lmf_mode_of(sel_b1, sel_b2);
    end
  end

  assign is_ring  = (mode_reg == LMF_RING);
  assign is_eth   = (mode_reg == LMF_ETH);
  // Ready is active low on the ring, carrier active high on Ethernet
  assign rx_valid = is_ring ? !ready_crs : (is_eth && ready_crs);

  ////////////////////////////////////////////////////////////////////////////
  // Control and interrupt registers
  logic [`LMF_CTRL_W-1:0] ctrl_reg;
  logic [`LMF_EV_W-1:0]   stat_reg;
  logic [`LMF_EV_W-1:0]   en_reg;
  logic [`LMF_EV_W-1:0]   clr_w;
  logic [`LMF_EV_W-1:0]   ev_w;
  logic                   ev_rx;
  logic                   ev_tx;
  logic                   ev_eth_collision_in;
  logic                   wr_ctrl;

  assign wr_ctrl = reg_wr && (reg_addr == `LMF_ADDR_CTRL);
  assign clr_w   = (reg_wr && reg_addr == `LMF_ADDR_IRQ_CLR) ?
                   reg_wdata[`LMF_EV_W-1:0] : '0;
  assign ev_w    = {ev_eth_collision_in, is_ring && fault_fall, ev_tx, ev_rx};

  // Control and enable writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `LMF_CTRL_RESET;
      en_reg   <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata[`LMF_CTRL_W-1:0];
      end
      if (reg_wr && reg_addr == `LMF_ADDR_IRQ_EN) begin
        en_reg <= reg_wdata[`LMF_EV_W-1:0];
      end
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= '0;
      irq      <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~clr_w) | ev_w;
      irq      <= |(stat_reg & en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive: bits gathered LSB first on the receive clock
  logic [DATA_W-1:0] rx_shift_reg;
  logic [DATA_W-1:0] rx_word_reg;
  logic [CW-1:0]     rx_cnt_reg;

  // An invalid line drops a partial word, so words stay aligned to frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_reg <= '0;
      rx_word_reg  <= '0;
      rx_cnt_reg   <= '0;
      ev_rx        <= 1'b0;
    end else begin
      ev_rx <= 1'b0;
      if (!rx_valid) begin
        rx_cnt_reg <= '0;
      end else if (rxc_rise) begin
        rx_shift_reg <= {rx_bit, rx_shift_reg[DATA_W-1:1]};
        if (rx_cnt_reg == CNT_FULL - 1'b1) begin
          rx_cnt_reg  <= '0;
          rx_word_reg <= {rx_bit, rx_shift_reg[DATA_W-1:1]};
          ev_rx       <= 1'b1;
        end else begin
          rx_cnt_reg <= rx_cnt_reg + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit: one word shifted out LSB first on the transmit clock
  logic [DATA_W-1:0] tx_shift_reg;
  logic [CW-1:0]     tx_cnt_reg;
  logic              tx_busy_reg;
  logic              tx_bit_reg;
  logic              tx_act_reg;

  // A write while busy is dropped; software polls busy or waits for done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_reg <= '0;
      tx_cnt_reg   <= '0;
      tx_busy_reg  <= 1'b0;
      tx_bit_reg   <= 1'b1;
      tx_act_reg   <= 1'b0;
      ev_tx        <= 1'b0;
    end else begin
      ev_tx <= 1'b0;
      if (reg_wr && reg_addr == `LMF_ADDR_TXDATA && !tx_busy_reg) begin
        tx_shift_reg <= reg_wdata[DATA_W-1:0];
        tx_cnt_reg   <= '0;
        tx_busy_reg  <= 1'b1;
      end else if (txc_rise && tx_busy_reg && !(mode_reg == LMF_RSVD)) begin
        if (tx_cnt_reg == CNT_FULL) begin
          tx_busy_reg <= 1'b0;
          tx_act_reg  <= 1'b0;
          ev_tx       <= 1'b1;
        end else begin
          tx_bit_reg   <= tx_shift_reg[0];
          tx_act_reg   <= 1'b1;
          tx_shift_reg <= tx_shift_reg >> 1;
          tx_cnt_reg   <= tx_cnt_reg + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Collision: accepted after it stands over two transmit clock edges
  logic [1:0] eth_collision_in_cnt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eth_collision_in_cnt_reg <= '0;
      ev_eth_collision_in      <= 1'b0;
    end else begin
      ev_eth_collision_in <= 1'b0;
      if (!(is_eth && fault_eth_collision_in)) begin
        eth_collision_in_cnt_reg <= '0;
      end else if (txc_rise && eth_collision_in_cnt_reg != ETH_COLLISION_IN_MIN) begin
        eth_collision_in_cnt_reg <= eth_collision_in_cnt_reg + 1'b1;
        ev_eth_collision_in      <= (eth_collision_in_cnt_reg == ETH_COLLISION_IN_MIN - 1'b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Insert pulse train; a steady level would let the watchdog drop us
  logic [INS_CW-1:0] ins_cnt_reg;
  logic              ins_on;

  assign ins_on = is_ring && ctrl_reg[`LMF_CTRL_INSERT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ins_cnt_reg <= '0;
    end else if (!ins_on || ins_cnt_reg == INS_LAST) begin
      ins_cnt_reg <= '0;
    end else begin
      ins_cnt_reg <= ins_cnt_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs, each from its own flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_tx_diff_out_p <= 1'b1;
      ring_tx_diff_out_n <= 1'b0;
      media_acq_txd      <= 1'b0;
      media_insert_loop  <= 1'b0;
      media_wrap_eth_tx_active    <= 1'b1;
    end else begin
      ring_tx_diff_out_p <= is_ring ? tx_bit_reg : 1'b1;
      ring_tx_diff_out_n <= is_ring ? !tx_bit_reg : 1'b0;
      unique case (mode_reg)
        LMF_RING: begin
          media_acq_txd     <= ctrl_reg[`LMF_CTRL_WIDE];
          media_insert_loop <= ins_on && (ins_cnt_reg < INS_HIGH);
          media_wrap_eth_tx_active   <= !ctrl_reg[`LMF_CTRL_LOOP];
        end
        LMF_ETH: begin
          media_acq_txd     <= tx_act_reg && tx_bit_reg;
          media_insert_loop <= ctrl_reg[`LMF_CTRL_LOOP];
          media_wrap_eth_tx_active   <= tx_act_reg;
        end
        default: begin
          media_acq_txd     <= 1'b0;
          media_insert_loop <= 1'b0;
          media_wrap_eth_tx_active   <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, data in the following cycle; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      unique case (reg_addr)
        `LMF_ADDR_CTRL:     reg_rdata[`LMF_CTRL_W-1:0] <= ctrl_reg;
        `LMF_ADDR_STATUS: begin
          reg_rdata[`LMF_ST_MODE_LSB+:2] <= mode_reg;
          reg_rdata[`LMF_ST_VALID]       <= rx_valid;
          reg_rdata[`LMF_ST_FAULT]       <= is_ring && !fault_eth_collision_in;
          reg_rdata[`LMF_ST_ETH_COLLISION_IN]        <= eth_collision_in_cnt_reg == ETH_COLLISION_IN_MIN;
          reg_rdata[`LMF_ST_BUSY]        <= tx_busy_reg;
        end
        `LMF_ADDR_RXDATA:   reg_rdata[DATA_W-1:0] <= rx_word_reg;
        `LMF_ADDR_IRQ_STAT: reg_rdata[`LMF_EV_W-1:0] <= stat_reg;
        `LMF_ADDR_IRQ_EN:   reg_rdata[`LMF_EV_W-1:0] <= en_reg;
        default:            reg_rdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int A_INS_MAX = `LMF_INS_PERIOD_CYC + 1;
  default clocking a_clk @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_mode_decode: assert property (
    sel_b1 && sel_b2 |=> mode_reg == LMF_RING)
    else $error("ring selects did not give ring mode");
  a_diff_pair: assert property (
    is_ring && $past(is_ring) |-> ring_tx_diff_out_p != ring_tx_diff_out_n)
    else $error("ring pair not complementary");
  a_acq_range: assert property (
    is_ring |=> media_acq_txd == $past(ctrl_reg[`LMF_CTRL_WIDE]))
    else $error("acquisition control wrong");
  a_insert_repeat: assert property (
    ins_on && !media_insert_loop |-> ##[1:A_INS_MAX] media_insert_loop)
    else $error("insert pulse missing");
  a_rx_take: assert property (
    is_ring && rx_valid && rxc_rise && rx_cnt_reg == '0
    |=> rx_cnt_reg == 1)
    else $error("received bit not taken");
  a_rx_ignore: assert property (
    is_ring && ready_crs |=> rx_cnt_reg == '0 && !ev_rx)
    else $error("data taken while not ready");
  a_fault_flag: assert property (
    is_ring && fault_fall |=> stat_reg[`LMF_EV_FAULT])
    else $error("wire fault not flagged");
  a_wrap_sel: assert property (
    is_ring |=> media_wrap_eth_tx_active == !$past(ctrl_reg[`LMF_CTRL_LOOP]))
    else $error("wrap select wrong");
  a_eth_pair: assert property (
    is_eth |=> ring_tx_diff_out_p && !ring_tx_diff_out_n)
    else $error("pair not at rest in Ethernet mode");
  a_txd_idle: assert property (
    is_eth && !tx_act_reg |=> !media_acq_txd)
    else $error("transmit data without enable");
  a_eth_loop: assert property (
    is_eth |=> media_insert_loop == $past(ctrl_reg[`LMF_CTRL_LOOP]))
    else $error("loopback output wrong");
  a_eth_tx_active_edge: assert property (
    $rose(tx_act_reg) |-> $past(txc_rise) ##1 (media_wrap_eth_tx_active || !is_eth))
    else $error("transmit enable off the clock");
endmodule : lmf_port

// file: lmf_media_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far-side transceiver: link clocks, received bits and status lines
module lmf_media_model (
  // Mode of the far side
  input  wire logic ring,
  // Lines towards the port
  output logic      ref_txc,
  output logic      rclk_rxc,
  output logic      rx_bit,
  output logic      ready_crs,
  output logic      fault_eth_collision_in
);
  localparam time HALF = 80ns;
  logic           busy;
  //////////////////////////////////////////////////////////////////////////////
  // Transmit clock runs free, offset 7 ns so its edges never land on a clk edge
  initial begin
    ref_txc = 1'b0;
    #7;
    forever #(HALF) ref_txc = ~ref_txc;
  end
  // Idle data keeps toggling so a stale bit can never pass as data
  initial begin
    busy       = 1'b0;
    rclk_rxc   = 1'b0;
    rx_bit     = 1'b0;
    ready_crs  = 1'b1;
    fault_eth_collision_in = 1'b1;
    forever #(HALF) if (!busy) rx_bit = ~rx_bit;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Rest levels: ring not ready, no fault; Ethernet no carrier, no collision
  task automatic set_idle();
    ready_crs  = ring;
    fault_eth_collision_in = ring;
  endtask : set_idle
  // One word, first bit LSB; receive clock stands still outside the frame
  task automatic send(input logic [7:0] d, input logic ok);
    busy      = 1'b1;
    ready_crs = ok ? ~ring : ring;
    for (int i = 0; i < 8; i++) begin
      rx_bit = d[i];
      #(HALF) rclk_rxc = 1'b1;
      #(HALF) rclk_rxc = 1'b0;
    end
    #(HALF) ready_crs = ring; // Carrier drops after the last bit
    busy = 1'b0;
  endtask : send
  // Fault (ring, low) or collision (Ethernet, high) for n transmit clocks
  task automatic fault(input int n);
    fault_eth_collision_in = ~ring;
    repeat (n) @(posedge ref_txc);
    fault_eth_collision_in = ring;
  endtask : fault
endmodule : lmf_media_model

// file: lmf_port_tb.sv
`timescale 1ns/1ps
`include "lmf_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the media front-end port
module lmf_port_tb;
  import lmf_pkg::*;
  localparam int DW = 8;
  logic        clk, reset_n, net_select_b1, net_select_b2, ring_md;
  wire         media_ref_txc, media_rclk_rxc, media_rx_bit;
  wire         media_ready_crs, media_fault_eth_collision_in;
  logic        ring_tx_diff_out_p, ring_tx_diff_out_n, media_acq_txd;
  logic        media_insert_loop, media_wrap_eth_tx_active, irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd;
  logic [7:0]  cap, d;
  int          cap_n, errors, checks, cyc, hi, lo;
  //////////////////////////////////////////////////////////////////////////////
  lmf_media_model lmf_media_model_inst (
    .ring(ring_md), .ref_txc(media_ref_txc), .rclk_rxc(media_rclk_rxc),
    .rx_bit(media_rx_bit), .ready_crs(media_ready_crs),
    .fault_eth_collision_in(media_fault_eth_collision_in));
  lmf_port #(.DATA_W(DW)) lmf_port_inst (
    .clk(clk), .reset_n(reset_n), .net_select_b1(net_select_b1),
    .net_select_b2(net_select_b2), .media_ref_txc(media_ref_txc),
    .media_rclk_rxc(media_rclk_rxc), .media_rx_bit(media_rx_bit),
    .media_ready_crs(media_ready_crs), .media_fault_eth_collision_in(media_fault_eth_collision_in),
    .ring_tx_diff_out_p(ring_tx_diff_out_p),
    .ring_tx_diff_out_n(ring_tx_diff_out_n), .media_acq_txd(media_acq_txd),
    .media_insert_loop(media_insert_loop), .media_wrap_eth_tx_active(media_wrap_eth_tx_active),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  //////////////////////////////////////////////////////////////////////////////
  // 50 MHz system clock
  initial clk = 1'b0;
  always #10 clk = ~clk;
  // Hang guard: whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      $display("wrong value at %0t: run timed out", $time);
      conclude();
    end
  end
  // Ring pair must stay complementary whenever the port runs in ring mode
  always @(posedge clk) begin
    if (ring_md === 1'b1 && reset_n === 1'b1 &&
        ring_tx_diff_out_p === ring_tx_diff_out_n) begin
      errors++;
      $display("wrong value at %0t: ring pair not complementary", $time);
    end
  end
  // Pick up Ethernet bits on the transceiver's own clock while enabled
  always @(posedge media_ref_txc) begin
    if (ring_md === 1'b0 && media_wrap_eth_tx_active === 1'b1) begin
      cap   <= {media_acq_txd, cap[7:1]};
      cap_n <= cap_n + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Step off the edge so far-side lines never move on a clk edge
    #1;
  endtask : wr
  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, exp);
  endtask : rdchk
  // Poll the sticky events for one bit, bounded
  task automatic wait_ev(input int b);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 300 && v[b] !== 1'b1; i++) begin
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= `LMF_ADDR_IRQ_STAT;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
    end
    chk(v[b], 1'b1);
  endtask : wait_ev
  // Selects change only while the port is held in reset
  task automatic rst(input logic b1, input logic b2);
    @(posedge clk);
    reset_n       <= 1'b0;
    net_select_b1 <= b1;
    net_select_b2 <= b2;
    ring_md       <= b1 & b2;
    tick(10);
    lmf_media_model_inst.set_idle();
    chk({ring_tx_diff_out_p, ring_tx_diff_out_n, media_acq_txd,
         media_insert_loop, media_wrap_eth_tx_active, irq}, 6'h22);
    @(posedge clk);
    reset_n <= 1'b1;
    tick(10);
  endtask : rst
  task automatic conclude();
    $display("errors %0d, checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, net_select_b1, net_select_b2, ring_md} = 4'h7;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {errors, checks, cyc, cap_n, cap} = '0;
    void'($urandom(32'hefef));
    // Ring mode: selects, controls, unmapped place
    rst(1'b1, 1'b1);
    rdchk(`LMF_ADDR_STATUS, 32'h3, 32'h0);
    rdchk(8'h1c, 32'hffffffff, 32'h0);
    wr(`LMF_ADDR_CTRL, 32'h1);
    tick(3);
    chk({media_acq_txd, media_wrap_eth_tx_active}, 2'h3);
    wr(`LMF_ADDR_CTRL, 32'h4);
    tick(3);
    chk({media_acq_txd, media_wrap_eth_tx_active}, 2'h0);
    // Ring transmit: pair rests on the last bit sent
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'($urandom) : 8'h7f;
      wr(`LMF_ADDR_TXDATA, {24'h0, d});
      wait_ev(`LMF_EV_TX);
      chk({ring_tx_diff_out_p, ring_tx_diff_out_n}, {d[7], ~d[7]});
      wr(`LMF_ADDR_IRQ_CLR, 32'hf);
    end
    // Ring receive with ready low, interrupt masked then enabled
    d = 8'($urandom);
    lmf_media_model_inst.send(d, 1'b1);
    tick(5);
    rdchk(`LMF_ADDR_RXDATA, 32'hff, {24'h0, d});
    rdchk(`LMF_ADDR_IRQ_STAT, 32'h1, 32'h1);
    chk(irq, 1'b0);
    wr(`LMF_ADDR_IRQ_EN, 32'h1);
    tick(3);
    chk(irq, 1'b1);
    wr(`LMF_ADDR_IRQ_CLR, 32'h1);
    tick(3);
    chk(irq, 1'b0);
    // Ready high: bits are ignored
    lmf_media_model_inst.send(~d, 1'b0);
    tick(5);
    rdchk(`LMF_ADDR_IRQ_STAT, 32'h1, 32'h0);
    rdchk(`LMF_ADDR_RXDATA, 32'hff, {24'h0, d});
    fork
      lmf_media_model_inst.fault(5);
      begin
        // The fault level needs the two sync flops before it is seen
        tick(3);
        rdchk(`LMF_ADDR_STATUS, 32'h8, 32'h8);
      end
    join
    rdchk(`LMF_ADDR_IRQ_STAT, 32'h4, 32'h4);
    // Insert train: high then low within one period, none when disabled
    wr(`LMF_ADDR_CTRL, 32'h2);
    for (int i = 0; i < 2000 && media_insert_loop !== 1'b1; i++) tick(1);
    for (hi = 0; hi < 2000 && media_insert_loop === 1'b1; hi++) tick(1);
    for (lo = 0; lo < 2000 && media_insert_loop !== 1'b1; lo++) tick(1);
    chk(hi, `LMF_INS_HIGH_CYC);
    chk(lo, `LMF_INS_PERIOD_CYC - `LMF_INS_HIGH_CYC);
    wr(`LMF_ADDR_CTRL, 32'h0);
    tick(3);
    for (hi = 0; hi < 900 && media_insert_loop === 1'b0; hi++) tick(1);
    chk(hi, 900);
    // Ethernet mode: select, rest pair, loopback request
    rst(1'b0, 1'b1);
    rdchk(`LMF_ADDR_STATUS, 32'h3, 32'h1);
    wr(`LMF_ADDR_CTRL, 32'h4);
    tick(3);
    chk(media_insert_loop, 1'b1);
    wr(`LMF_ADDR_CTRL, 32'h0);
    tick(3);
    chk(media_insert_loop, 1'b0);
    // Ethernet transmit: bits on the transmit clock, enable framing them
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 8'h01 : (k == 1) ? 8'hfe : 8'($urandom);
      chk(media_wrap_eth_tx_active, 1'b0);
      cap_n = 0;
      wr(`LMF_ADDR_TXDATA, {24'h0, d});
      wait_ev(`LMF_EV_TX);
      tick(3);
      chk(cap, d);
      chk(cap_n, DW);
      chk({ring_tx_diff_out_p, ring_tx_diff_out_n}, 2'h2);
      wr(`LMF_ADDR_IRQ_CLR, 32'hf);
    end
    // Ethernet receive under carrier, then collisions long and short
    d = 8'($urandom);
    lmf_media_model_inst.send(d, 1'b1);
    tick(5);
    rdchk(`LMF_ADDR_RXDATA, 32'hff, {24'h0, d});
    fork
      lmf_media_model_inst.fault(5);
      begin
        tick(28);
        rdchk(`LMF_ADDR_STATUS, 32'h10, 32'h10);
      end
    join
    rdchk(`LMF_ADDR_IRQ_STAT, 32'h8, 32'h8);
    wr(`LMF_ADDR_IRQ_CLR, 32'hf);
    lmf_media_model_inst.fault(1);
    tick(20);
    rdchk(`LMF_ADDR_IRQ_STAT, 32'h8, 32'h0);
    conclude();
  end
endmodule : lmf_port_tb
